// File: rtl/eeprom_link_pkg.sv
// Constants shared by the EEPROM slave front end and its bus master.
// Assumes a 250 MHz system clock; the slave also has its own link clock.
// How it works
// - Ignore bus until a start is seen
// - SDA rising, SCL high ends operation
// - Master keeps SDA steady while SCL high
// - Sample on SCL high, change on low
// - One SCL pulse per data bit
// - Master makes SCL, start, stop; bus idle
// - Master ends every operation with stop
// - Receiver acknowledges by pulling SDA low
// - Address byte: upper four bits type code
// - Next three bits match strapped select pins
// - Unconnected select pins read as zero
// - Last address bit: one read, zero write
// - Matching address acked on ninth clock
// - Selected device keeps watching, readies direction
// - Write-protect high refuses every array write
// - SDA only pulled low or released
// - Any start resets the serial interface
// - Master recovers bus with nine SCL pulses
// - Standby at power-up, after stop, write
// - No address ack during internal write

package eeprom_link_pkg;

  // ----------------------------------------
  // Clock and bus timing
  // ----------------------------------------
  localparam int SYS_MHZ       = 250;
  localparam int SCL_PERIOD_NS = 2500;
  // Quarter period rounded down keeps SCL at or just above its rate
  localparam int QTR_CYC       = SCL_PERIOD_NS * SYS_MHZ / 1000 / 4;
  localparam int QTR_W         = 8;
  localparam logic [QTR_W-1:0] QTR_LAST = QTR_W'(QTR_CYC - 1);

  // ----------------------------------------
  // Address byte layout
  // ----------------------------------------
  localparam int BYTE_W   = 8;
  localparam int BYTE_MSB = BYTE_W - 1;
  localparam int TYPE_W   = 4;
  localparam int SEL_W    = 3;
  localparam int ADDR7_W  = TYPE_W + SEL_W;
  localparam int TYPE_LSB = 4;
  localparam int SEL_LSB  = 1;
  localparam int RW_BIT   = 0;
  localparam logic RW_READ = 1'h1;
  // Arbitrary value, not tied to any real part
  localparam logic [TYPE_W-1:0] DEV_TYPE_CODE = 4'h6;

  // ----------------------------------------
  // Bit and phase counts
  // ----------------------------------------
  localparam int BIT_W = 4;
  localparam logic [BIT_W-1:0] ADDR_BITS   = 4'h8;
  localparam logic [BIT_W-1:0] ACK_IDX     = 4'h8;
  localparam logic [BIT_W-1:0] RECOV_LAST  = 4'h8;
  localparam logic [BIT_W-1:0] BIT_ZERO    = 4'h0;
  localparam logic [BIT_W-1:0] BIT_ONE     = 4'h1;
  localparam logic [1:0]       PH_0        = 2'h0;
  localparam logic [1:0]       PH_1        = 2'h1;
  localparam logic [1:0]       PH_2        = 2'h2;
  localparam logic [1:0]       PH_3        = 2'h3;

endpackage

// File: rtl/two_wire_if.sv
// Two-wire bus carrier joining the master end and the slave end.
// Assumes a pull-up on both lines; the wire levels are resolved here.
`timescale 1ns/1ns
`default_nettype none

interface two_wire_if;

  // ----------------------------------------
  // Driver side of each pin
  // ----------------------------------------
  logic m_scl_oe;
  logic m_scl_out;
  logic m_sda_oe;
  logic m_sda_out;
  logic d_sda_oe;
  logic d_sda_out;

  // ----------------------------------------
  // Resolved wire levels
  // ----------------------------------------
  logic scl;
  logic sda;

  // Wired-AND with pull-up; a released line reads high
  assign scl = ~(m_scl_oe & ~m_scl_out);
  assign sda = ~((m_sda_oe & ~m_sda_out) | (d_sda_oe & ~d_sda_out));

  modport mst (
    output m_scl_oe,
    output m_scl_out,
    output m_sda_oe,
    output m_sda_out,
    input  scl,
    input  sda
  );

  modport dev (
    output d_sda_oe,
    output d_sda_out,
    input  scl,
    input  sda
  );

endinterface

`default_nettype wire

// File: rtl/eeprom_front_end.sv
// Slave front end of a two-wire EEPROM.
// Assumes bus logic runs on link_clk_i, much faster than SCL, and the
// memory side on sys_clk_i; sync3 lives in the master file.
`timescale 1ns/1ns
`default_nettype none

module eeprom_front_end #(
  parameter logic [eeprom_link_pkg::TYPE_W-1:0] TYPE_CODE =
    eeprom_link_pkg::DEV_TYPE_CODE
) (
  // Clocks and reset
  input  wire logic                              sys_clk_i,
  input  wire logic                              link_clk_i,
  input  wire logic                              reset_i,
  // Two-wire bus
  two_wire_if.dev                                link,
  // Straps and memory side
  input  wire logic [eeprom_link_pkg::SEL_W-1:0] device_select_pins_i,
  input  wire logic                              wp_i,
  input  wire logic                              write_busy_i,
  // Selection results
  output var  logic                              sel_pulse_o,
  output var  logic                              sel_read_o,
  output var  logic                              write_ok_o,
  output var  logic                              stop_pulse_o,
  output var  logic                              standby_o
);
  import eeprom_link_pkg::*;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_ADDR = 5'h02,
    ST_ACK  = 5'h04,
    ST_SEL  = 5'h08,
    ST_SKIP = 5'h10
  } dev_state_t;

  dev_state_t        state_r;
  logic              scl_f;
  logic              sda_f;
  logic              scl_p_r;
  logic              sda_p_r;
  logic [SEL_W-1:0]  sel_s;
  logic              wp_s;
  logic              busy_s;
  logic              busy_p_r;
  logic [BYTE_W-1:0] shift_r;
  logic [BIT_W-1:0]  bit_cnt_r;
  logic              sda_oe_r;
  logic              dir_r;
  logic              wok_r;
  logic              sel_tog_r;
  logic              stop_tog_r;
  logic              standby_r;
  logic              start_c;
  logic              stop_c;
  logic              rise_c;
  logic              fall_c;
  logic              addr_done_c;
  logic              sel_tog_s;
  logic              stop_tog_s;
  logic              dir_s;
  logic              wok_s;
  logic              standby_s;
  logic              sel_seen_r;
  logic              stop_seen_r;

  function automatic logic addr_match(
    input logic [BYTE_W-1:0] b,
    input logic [SEL_W-1:0]  s,
    input logic              busy
  );
    return (b[BYTE_MSB:TYPE_LSB] == TYPE_CODE) &&
           (b[TYPE_LSB-1:SEL_LSB] == s) && !busy;
  endfunction

  // ----------------------------------------
  // Link-side input conditioning
  // ----------------------------------------
  sync3 #(.W(2), .RST(2'h3)) u_bus_sync (
    .clk_i   (link_clk_i),
    .reset_i (reset_i),
    .d_i     ({link.scl, link.sda}),
    .q_o     ({scl_f, sda_f})
  );

  // Floating select pins rely on pad pull-downs
  sync3 #(.W(SEL_W + 2), .RST('0)) u_strap_sync (
    .clk_i   (link_clk_i),
    .reset_i (reset_i),
    .d_i     ({device_select_pins_i, wp_i, write_busy_i}),
    .q_o     ({sel_s, wp_s, busy_s})
  );

  always_ff @(posedge link_clk_i or posedge reset_i) begin
    if (reset_i) begin
      scl_p_r  <= 1'h1;
      sda_p_r  <= 1'h1;
      busy_p_r <= 1'h0;
    end else begin
      scl_p_r  <= scl_f;
      sda_p_r  <= sda_f;
      busy_p_r <= busy_s;
    end
  end

  assign start_c = scl_f & scl_p_r & sda_p_r & ~sda_f;
  assign stop_c  = scl_f & scl_p_r & ~sda_p_r & sda_f;
  assign rise_c  = scl_f & ~scl_p_r;
  assign fall_c  = ~scl_f & scl_p_r;
  assign addr_done_c = (state_r == ST_ADDR) && fall_c &&
                       (bit_cnt_r == ADDR_BITS);

  // ----------------------------------------
  // Sequencing
  // ----------------------------------------
  always_ff @(posedge link_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_r <= ST_IDLE;
    end else if (start_c) begin
      state_r <= ST_ADDR;
    end else if (stop_c) begin
      state_r <= ST_IDLE;
    end else begin
      case (state_r)
        ST_ADDR: begin
          if (addr_done_c) begin
            // Mismatch waits out the frame silently
            state_r <= addr_match(shift_r, sel_s, busy_s) ?
                       ST_ACK : ST_SKIP;
          end
        end
        ST_ACK: begin
          if (fall_c) begin
            state_r <= ST_SEL;
          end
        end
        ST_IDLE, ST_SEL, ST_SKIP: begin
          state_r <= state_r;
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Address shifter
  // ----------------------------------------
  always_ff @(posedge link_clk_i or posedge reset_i) begin
    if (reset_i) begin
      shift_r   <= '0;
      bit_cnt_r <= BIT_ZERO;
    end else if (start_c) begin
      bit_cnt_r <= BIT_ZERO;
    end else if (state_r == ST_ADDR && rise_c &&
                 bit_cnt_r != ADDR_BITS) begin
      // One bit per SCL high
      shift_r   <= {shift_r[BYTE_MSB-1:0], sda_f};
      bit_cnt_r <= bit_cnt_r + BIT_ONE;
    end
  end

  // ----------------------------------------
  // Acknowledge driver
  // ----------------------------------------
  always_ff @(posedge link_clk_i or posedge reset_i) begin
    if (reset_i) begin
      sda_oe_r <= 1'h0;
    end else if (start_c || stop_c) begin
      sda_oe_r <= 1'h0;
    end else if (addr_done_c) begin
      // Busy write cycle blocks the ack for polling
      sda_oe_r <= addr_match(shift_r, sel_s, busy_s);
    end else if (state_r == ST_ACK && fall_c) begin
      sda_oe_r <= 1'h0;
    end
  end

  // Open drain: value is always low, only the enable moves
  assign link.d_sda_oe  = sda_oe_r;
  assign link.d_sda_out = 1'h0;

  // ----------------------------------------
  // Direction and write permission
  // ----------------------------------------
  always_ff @(posedge link_clk_i or posedge reset_i) begin
    if (reset_i) begin
      dir_r <= 1'h0;
      wok_r <= 1'h0;
    end else if (start_c) begin
      wok_r <= 1'h0;
    end else if (addr_done_c) begin
      dir_r <= (shift_r[RW_BIT] == RW_READ);
      wok_r <= (shift_r[RW_BIT] != RW_READ) && !wp_s &&
               addr_match(shift_r, sel_s, busy_s);
    end
  end

  // ----------------------------------------
  // Events and standby
  // ----------------------------------------
  always_ff @(posedge link_clk_i or posedge reset_i) begin
    if (reset_i) begin
      sel_tog_r  <= 1'h0;
      stop_tog_r <= 1'h0;
    end else begin
      if (state_r == ST_ACK && fall_c && !start_c && !stop_c) begin
        sel_tog_r <= ~sel_tog_r;
      end
      if (stop_c) begin
        stop_tog_r <= ~stop_tog_r;
      end
    end
  end

  always_ff @(posedge link_clk_i or posedge reset_i) begin
    if (reset_i) begin
      standby_r <= 1'h1;
    end else begin
      if (scl_f != scl_p_r || sda_f != sda_p_r) begin
        standby_r <= 1'h0;
      end
      // Entries written last so they win over bus activity
      if (stop_c && !(state_r == ST_SEL && wok_r)) begin
        standby_r <= 1'h1;
      end
      if (busy_p_r && !busy_s) begin
        standby_r <= 1'h1;
      end
    end
  end

  // ----------------------------------------
  // Crossing to the memory side
  // ----------------------------------------
  // Levels settle well before the toggle that announces them
  sync3 #(.W(5), .RST(5'h01)) u_out_sync (
    .clk_i   (sys_clk_i),
    .reset_i (reset_i),
    .d_i     ({sel_tog_r, stop_tog_r, dir_r, wok_r, standby_r}),
    .q_o     ({sel_tog_s, stop_tog_s, dir_s, wok_s, standby_s})
  );

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      sel_seen_r   <= 1'h0;
      stop_seen_r  <= 1'h0;
      sel_pulse_o  <= 1'h0;
      stop_pulse_o <= 1'h0;
      sel_read_o   <= 1'h0;
      write_ok_o   <= 1'h0;
      standby_o    <= 1'h1;
    end else begin
      sel_seen_r   <= sel_tog_s;
      stop_seen_r  <= stop_tog_s;
      sel_pulse_o  <= sel_tog_s ^ sel_seen_r;
      stop_pulse_o <= stop_tog_s ^ stop_seen_r;
      sel_read_o   <= dir_s;
      write_ok_o   <= wok_s;
      standby_o    <= standby_s;
    end
  end

endmodule

`default_nettype wire

// File: rtl/two_wire_master.sv
// Bus master end (start, address byte, ack slot, stop) and sync3,
// the three-stage input filter both ends use; SCL is divided from sys_clk_i.
`timescale 1ns/1ns
`default_nettype none

module sync3 #(
  parameter int             W   = 1,
  parameter logic [W-1:0]   RST = '0
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         reset_i,
  // Data
  input  wire logic [W-1:0] d_i,
  output var  logic [W-1:0] q_o
);

  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  // ----------------------------------------
  // Stage chain; only the second stage reads the first
  // ----------------------------------------
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      s1_r <= RST;
      s2_r <= RST;
      s3_r <= RST;
      q_o  <= RST;
    end else begin
      s1_r <= d_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      // Glitch filter: accept only once stages two and three agree
      if (s2_r == s3_r) begin
        q_o <= s3_r;
      end
    end
  end

endmodule

module two_wire_master (
  // Clock and reset
  input  wire logic                                sys_clk_i,
  input  wire logic                                reset_i,
  // Two-wire bus
  two_wire_if.mst                                  link,
  // Command port
  input  wire logic                                cmd_valid_i,
  input  wire logic [eeprom_link_pkg::ADDR7_W-1:0] cmd_addr_i,
  input  wire logic                                cmd_read_i,
  output var  logic                                cmd_ready_o,
  output var  logic                                done_o,
  output var  logic                                acked_o
);
  import eeprom_link_pkg::*;

  typedef enum logic [4:0] {
    M_IDLE  = 5'h01,
    M_RECOV = 5'h02,
    M_START = 5'h04,
    M_BITS  = 5'h08,
    M_STOP  = 5'h10
  } mst_state_t;

  mst_state_t        state_r;
  logic [QTR_W-1:0]  qcnt_r;
  logic              tick_c;
  logic [1:0]        ph_r;
  logic [BIT_W-1:0]  idx_r;
  logic [BIT_W-1:0]  rec_r;
  logic              rec_ok_r;
  logic [BYTE_W-1:0] byte_r;
  logic              scl_oe_r;
  logic              sda_oe_r;
  logic              sda_s;
  logic              accept_c;

  // Wire level seen back through the filter
  sync3 #(.W(1), .RST(1'h1)) u_sda_sync (
    .clk_i   (sys_clk_i),
    .reset_i (reset_i),
    .d_i     (link.sda),
    .q_o     (sda_s)
  );

  assign accept_c = (state_r == M_IDLE) && cmd_valid_i && cmd_ready_o;
  assign tick_c   = (state_r != M_IDLE) && (qcnt_r == QTR_LAST);

  // ----------------------------------------
  // Quarter-period divider
  // ----------------------------------------
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      qcnt_r <= '0;
    end else if (state_r == M_IDLE || tick_c) begin
      qcnt_r <= '0;
    end else begin
      qcnt_r <= qcnt_r + QTR_W'(1);
    end
  end

  // ----------------------------------------
  // Sequencing
  // ----------------------------------------
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_r  <= M_IDLE;
      ph_r     <= PH_0;
      idx_r    <= BIT_ZERO;
      rec_r    <= BIT_ZERO;
      rec_ok_r <= 1'h0;
    end else if (accept_c) begin
      // A held-low SDA means a slave is stuck mid-byte
      state_r <= sda_s ? M_START : M_RECOV;
      ph_r    <= PH_0;
      rec_r   <= BIT_ZERO;
    end else if (tick_c) begin
      ph_r <= ph_r + PH_1;
      case (state_r)
        M_RECOV: begin
          if (ph_r == PH_2) begin
            rec_ok_r <= sda_s;
          end else if (ph_r == PH_3) begin
            if (rec_ok_r || rec_r == RECOV_LAST) begin
              state_r <= M_START;
            end
            rec_r <= rec_r + BIT_ONE;
          end
        end
        M_START: begin
          if (ph_r == PH_3) begin
            state_r <= M_BITS;
            idx_r   <= BIT_ZERO;
          end
        end
        M_BITS: begin
          if (ph_r == PH_3) begin
            if (idx_r == ACK_IDX) begin
              state_r <= M_STOP;
            end
            idx_r <= idx_r + BIT_ONE;
          end
        end
        M_STOP: begin
          if (ph_r == PH_3) begin
            state_r <= M_IDLE;
          end
        end
        default: begin
          state_r <= M_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Pin drive: data moves only while SCL is low
  // ----------------------------------------
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      scl_oe_r <= 1'h0;
      sda_oe_r <= 1'h0;
    end else if (tick_c) begin
      case (state_r)
        M_RECOV: begin
          if (ph_r == PH_0) begin
            sda_oe_r <= 1'h0;
            scl_oe_r <= 1'h1;
          end else if (ph_r == PH_1) begin
            scl_oe_r <= 1'h0;
          end else if (ph_r == PH_3 && !rec_ok_r &&
                       rec_r != RECOV_LAST) begin
            scl_oe_r <= 1'h1;
          end
        end
        M_START: begin
          if (ph_r == PH_0) begin
            scl_oe_r <= 1'h0;
            sda_oe_r <= 1'h0;
          end else if (ph_r == PH_2) begin
            sda_oe_r <= 1'h1;
          end else if (ph_r == PH_3) begin
            scl_oe_r <= 1'h1;
          end
        end
        M_BITS: begin
          if (ph_r == PH_0) begin
            // Ack slot left released for the slave
            sda_oe_r <= (idx_r != ACK_IDX) && !byte_r[BYTE_MSB];
          end else if (ph_r == PH_1) begin
            scl_oe_r <= 1'h0;
          end else if (ph_r == PH_3) begin
            scl_oe_r <= 1'h1;
          end
        end
        M_STOP: begin
          if (ph_r == PH_0) begin
            sda_oe_r <= 1'h1;
          end else if (ph_r == PH_1) begin
            scl_oe_r <= 1'h0;
          end else if (ph_r == PH_2) begin
            sda_oe_r <= 1'h0;
          end
        end
        default: begin
          scl_oe_r <= 1'h0;
          sda_oe_r <= 1'h0;
        end
      endcase
    end
  end

  assign link.m_scl_oe  = scl_oe_r;
  assign link.m_sda_oe  = sda_oe_r;
  assign link.m_scl_out = 1'h0;
  assign link.m_sda_out = 1'h0;

  // ----------------------------------------
  // Byte, ack capture and handshake
  // ----------------------------------------
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      byte_r      <= '0;
      acked_o     <= 1'h0;
      done_o      <= 1'h0;
      cmd_ready_o <= 1'h1;
    end else begin
      done_o <= 1'h0;
      if (accept_c) begin
        byte_r      <= {cmd_addr_i, cmd_read_i};
        cmd_ready_o <= 1'h0;
      end else if (tick_c && state_r == M_BITS && ph_r == PH_2) begin
        if (idx_r == ACK_IDX) begin
          acked_o <= !sda_s;
        end else begin
          byte_r <= {byte_r[BYTE_MSB-1:0], 1'h0};
        end
      end else if (tick_c && state_r == M_STOP && ph_r == PH_3) begin
        done_o      <= 1'h1;
        cmd_ready_o <= 1'h1;
      end
    end
  end

endmodule

`default_nettype wire

// File: sim/two_wire_asserts.sv
// Concurrent checks on the bus between the master and slave ends.
// Assumes the bench instantiates it beside the interface instance.
`timescale 1ns/1ns
`default_nettype none

module two_wire_asserts (
  // Clocks and reset
  input wire logic sys_clk_i,
  input wire logic link_clk_i,
  input wire logic reset_i,
  // Bus signals
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic d_sda_oe_i,
  input wire logic d_sda_out_i,
  // Slave side
  input wire logic wp_i,
  input wire logic write_busy_i,
  input wire logic sel_pulse_i,
  input wire logic sel_read_i,
  input wire logic write_ok_i,
  input wire logic stop_pulse_i,
  input wire logic standby_i
);
  // ----------------------------------------
  // Link clock domain
  // ----------------------------------------
  a_drive_low_only:
    assert property (@(posedge link_clk_i) disable iff (reset_i)
      d_sda_oe_i |-> !d_sda_out_i) else $error("slave drove SDA high");
  a_ack_rise_low:
    assert property (@(posedge link_clk_i) disable iff (reset_i)
      $rose(d_sda_oe_i) |-> !scl_i)
      else $error("ack taken while SCL high");
  a_ack_fall_low:
    assert property (@(posedge link_clk_i) disable iff (reset_i)
      $fell(d_sda_oe_i) |-> !scl_i)
      else $error("ack dropped while SCL high");
  a_ack_held_high:
    assert property (@(posedge link_clk_i) disable iff (reset_i)
      scl_i && d_sda_oe_i |=> d_sda_oe_i || !scl_i)
      else $error("ack lost early");
  // Ack spans one full ninth clock, about 31 link clocks
  a_ack_one_clock:
    assert property (@(posedge link_clk_i) disable iff (reset_i)
      $rose(d_sda_oe_i) |-> ##26 d_sda_oe_i ##[1:10] !d_sda_oe_i)
      else $error("ack length wrong");
  a_busy_no_ack:
    assert property (@(posedge link_clk_i) disable iff (reset_i)
      write_busy_i && $past(write_busy_i, 8) |-> !$rose(d_sda_oe_i))
      else $error("ack while busy");
  // ----------------------------------------
  // System clock domain
  // ----------------------------------------
  a_stop_seen:
    assert property (@(posedge sys_clk_i) disable iff (reset_i)
      scl_i && $rose(sda_i) |-> ##[1:200] stop_pulse_i)
      else $error("stop missed");
  a_sel_after_ack:
    assert property (@(posedge sys_clk_i) disable iff (reset_i)
      $fell(d_sda_oe_i) |-> ##[1:40] sel_pulse_i)
      else $error("select missed");
  a_write_ok_dir:
    assert property (@(posedge sys_clk_i) disable iff (reset_i)
      sel_pulse_i |-> write_ok_i == (!sel_read_i && !wp_i))
      else $error("write permission wrong");
  a_standby_stop:
    assert property (@(posedge sys_clk_i) disable iff (reset_i)
      stop_pulse_i && !write_ok_i |-> ##[0:60] standby_i)
      else $error("standby missed");
  c_ack: cover property (@(posedge link_clk_i) $rose(d_sda_oe_i));
  c_read: cover property (@(posedge sys_clk_i) sel_pulse_i && sel_read_i);
  c_stop: cover property (@(posedge sys_clk_i) stop_pulse_i);
endmodule

`default_nettype wire

// File: sim/tb_top.sv
// Bench joining the master end and the slave end over one bus.
// Assumes the package, interface and both design files compile first.
`timescale 1ns/1ns
`default_nettype none

module tb_top;
  import eeprom_link_pkg::*;
  // ----------------------------------------
  // Stimulus and observation
  // ----------------------------------------
  logic               sys_clk_i = 1'h0;
  logic               link_clk  = 1'h0;
  logic               reset_i   = 1'h1;
  logic [SEL_W-1:0]   pins      = 3'h5;
  logic               wp        = 1'h0;
  logic               busy      = 1'h0;
  logic               cmd_valid = 1'h0;
  logic [ADDR7_W-1:0] cmd_addr  = '0;
  logic               cmd_read  = 1'h0;
  logic               sel_pulse, sel_read, write_ok, stop_pulse, standby;
  logic               cmd_ready, done, acked;
  int                 fail_count   = 0;
  int                 total_checks = 0;
  int                 sel_cnt      = 0;
  int                 stop_cnt     = 0;
  localparam logic [ADDR7_W-1:0] MATCH = {DEV_TYPE_CODE, 3'h5};

  two_wire_if bus ();
  eeprom_front_end i_eeprom_front_end (
    .sys_clk_i(sys_clk_i), .link_clk_i(link_clk), .reset_i(reset_i),
    .link(bus), .device_select_pins_i(pins), .wp_i(wp),
    .write_busy_i(busy), .sel_pulse_o(sel_pulse), .sel_read_o(sel_read),
    .write_ok_o(write_ok), .stop_pulse_o(stop_pulse), .standby_o(standby));
  two_wire_master i_two_wire_master (
    .sys_clk_i(sys_clk_i), .reset_i(reset_i), .link(bus),
    .cmd_valid_i(cmd_valid), .cmd_addr_i(cmd_addr), .cmd_read_i(cmd_read),
    .cmd_ready_o(cmd_ready), .done_o(done), .acked_o(acked));
  two_wire_asserts i_two_wire_asserts (
    .sys_clk_i(sys_clk_i), .link_clk_i(link_clk), .reset_i(reset_i),
    .scl_i(bus.scl), .sda_i(bus.sda), .d_sda_oe_i(bus.d_sda_oe),
    .d_sda_out_i(bus.d_sda_out), .wp_i(wp), .write_busy_i(busy),
    .sel_pulse_i(sel_pulse), .sel_read_i(sel_read), .write_ok_i(write_ok),
    .stop_pulse_i(stop_pulse), .standby_i(standby));

  // Link clock offset so its edges never meet the system edges
  always #2 sys_clk_i = ~sys_clk_i;
  initial begin
    #3;
    forever #40 link_clk = ~link_clk;
  end
  always @(posedge sys_clk_i) begin
    if (sel_pulse === 1'h1) sel_cnt <= sel_cnt + 1;
    if (stop_pulse === 1'h1) stop_cnt <= stop_cnt + 1;
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask

  // One full command; the stop pulse crosses before done, the slack after done is margin
  task automatic run(input logic [ADDR7_W-1:0] a, input logic rd,
                     input logic ack, input logic stby);
    int s0;
    int p0;
    int n;
    s0 = sel_cnt;
    p0 = stop_cnt;
    n = 0;
    @(negedge sys_clk_i);
    cmd_addr = a;
    cmd_read = rd;
    cmd_valid = 1'h1;
    @(negedge sys_clk_i);
    cmd_valid = 1'h0;
    while (done !== 1'h1 && n < 9000) begin
      @(negedge sys_clk_i);
      n++;
    end
    chk("done in time", 32'h1, 32'(n < 9000));
    wait_cyc(200);
    chk("acked", 32'(ack), 32'(acked));
    chk("select count", 32'(ack), 32'(sel_cnt - s0));
    chk("stop count", 32'h1, 32'(stop_cnt - p0));
    chk("standby", 32'(stby), 32'(standby));
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset_state();
    chk("standby at reset", 32'h1, 32'(standby));
    chk("ready at reset", 32'h1, 32'(cmd_ready));
  endtask

  task automatic t_mismatch();
    run({~DEV_TYPE_CODE, 3'h5}, 1'h0, 1'h0, 1'h1);
    run({DEV_TYPE_CODE, 3'h4}, 1'h0, 1'h0, 1'h1);
  endtask

  task automatic t_read();
    run(MATCH, 1'h1, 1'h1, 1'h1);
    chk("read select", 32'h1, 32'(sel_read));
  endtask

  task automatic t_write();
    run(MATCH, 1'h0, 1'h1, 1'h0);
    chk("write select", 32'h0, 32'(sel_read));
    chk("write ok", 32'h1, 32'(write_ok));
    busy = 1'h1;
    wait_cyc(100);
    busy = 1'h0;
    // Busy fall crosses into the link side and back: about 420 ns
    wait_cyc(200);
    chk("standby after write", 32'h1, 32'(standby));
  endtask

  task automatic t_busy();
    busy = 1'h1;
    wait_cyc(100);
    run(MATCH, 1'h0, 1'h0, 1'h1);
    busy = 1'h0;
    wait_cyc(100);
  endtask

  task automatic t_protect();
    wp = 1'h1;
    run(MATCH, 1'h0, 1'h1, 1'h1);
    chk("protected write", 32'h0, 32'(write_ok));
    wp = 1'h0;
  endtask

  task automatic t_pins_zero();
    pins = 3'h0;
    wait_cyc(100);
    run({DEV_TYPE_CODE, 3'h0}, 1'h1, 1'h1, 1'h1);
    pins = 3'h5;
  endtask

  task automatic end_of_test();
    if (fail_count == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge link_clk);
    @(negedge sys_clk_i);
    reset_i = 1'h0;
    wait_cyc(300);
    t_reset_state();
    t_mismatch();
    t_read();
    t_write();
    t_busy();
    t_protect();
    t_pins_zero();
    end_of_test();
  end

  // Seven commands take about 50000 cycles; the rest is slack
  initial begin
    #(90000 * 4);
    fail_count++;
    $display("unexpected run time expected finish seen timeout");
    end_of_test();
  end
endmodule

`default_nettype wire
